// file: core/fsps_arm_timer.v
// Purpose: arm window counter for store or load instructions
// Assumes: start pulses load the window, hit ends it
// Notes:   active stays high for exactly the loaded count
`timescale 1ns/10ps
`include "fsps_defines.vh"

module fsps_arm_timer (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       start,
  input  wire [2:0] cycles,
  input  wire       hit,
  output wire       active,
  output wire       expired
);
  reg [2:0] cnt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'd0;
    end else if (start) begin
      cnt_q <= cycles;
    end else if (hit) begin
      cnt_q <= 3'd0;
    end else if (cnt_q != 3'd0) begin
      cnt_q <= cnt_q - 3'd1;
    end
  end

  assign active  = (cnt_q != 3'd0);
  // one cycle pulse when the window lapses unused
  assign expired = (cnt_q == 3'd1) && !hit && !start;
endmodule // fsps_arm_timer

// file: core/fsps_defines.vh
// Purpose: constants for the flash self-program sequencer
// Assumes: 125 MHz core clock, APB register access
// Notes:   offsets are byte addresses on the APB bus
`ifndef FSPS_DEFINES_VH
`define FSPS_DEFINES_VH

`define FSPS_CLK_MHZ          125
`define FSPS_OFF_CTRL         12'h000
`define FSPS_OFF_LOCK         12'h004
`define FSPS_OFF_PAGE         12'h008
`define FSPS_OFF_STATUS       12'h00c

`define FSPS_CTRL_RESET       8'h00
`define FSPS_LOCK_RESET       8'hff
`define FSPS_FUSE_LOW_RESET   8'hff
`define FSPS_FUSE_HIGH_RESET  8'hff
`define FSPS_FUSE_EXT_RESET   8'hff

`define FSPS_BIT_STORE_EN     0
`define FSPS_BIT_ERASE        1
`define FSPS_BIT_WRITE        2
`define FSPS_BIT_LOCK_SET     3
`define FSPS_BIT_REENABLE     4
`define FSPS_BIT_BUSY_FLAG    6
`define FSPS_BIT_READY_IE     7

`define FSPS_CMD_LOCK         5'h09
`define FSPS_CMD_WRITE        5'h05
`define FSPS_CMD_ERASE        5'h03
`define FSPS_CMD_LOAD         5'h01
`define FSPS_CMD_REENABLE     5'h11

`define FSPS_STORE_WINDOW     3'd4
`define FSPS_LOAD_WINDOW      3'd3

`define FSPS_WORD_BITS        6
`define FSPS_PAGE_BITS        7
`define FSPS_PAGE_WORDS       64
`define FSPS_STALL_PAGE_FIRST 7'h70

`define FSPS_PROG_MIN_US      3700
`define FSPS_PROG_MAX_US      4500
`define FSPS_PROG_CYCLES      (`FSPS_PROG_MIN_US * `FSPS_CLK_MHZ)

`define FSPS_Z_LOCK           16'h0001
`define FSPS_Z_FUSE_LOW       16'h0000
`define FSPS_Z_FUSE_EXT       16'h0002
`define FSPS_Z_FUSE_HIGH      16'h0003

`endif

// file: core/fsps_page_buffer.v
// Purpose: temporary page buffer, one 16-bit word per slot
// Assumes: clear has priority over write
// Notes:   unloaded slots read as erased flash (all ones)
`timescale 1ns/10ps
`include "fsps_defines.vh"

module fsps_page_buffer (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clear,
  input  wire        wr_en,
  input  wire [5:0]  wr_idx,
  input  wire [15:0] wr_data,
  input  wire [5:0]  rd_idx,
  output wire [15:0] rd_data
);
  reg [15:0] mem_q [0:`FSPS_PAGE_WORDS-1];
  integer i;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `FSPS_PAGE_WORDS; i = i + 1) begin
        mem_q[i] <= 16'hffff;
      end
    end else if (clear) begin
      for (i = 0; i < `FSPS_PAGE_WORDS; i = i + 1) begin
        mem_q[i] <= 16'hffff;
      end
    end else if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_idx];
endmodule // fsps_page_buffer

// file: core/fsps_sequencer.v
// Purpose: flash self-program sequencer with APB control access
// Assumes: core signals store/load instruction pulses with Z and R1:R0
// Notes:   flash array handled by outside macro via page strobes
// Overview of operation
// (RULE1) software erases page before writing it
// (RULE2) store loads one 16-bit word from R1:R0
// (RULE3) buffer words load in any order
// (RULE4) erase: X0000011 then store within four
// (RULE5) erase and write use Z page field
// (RULE6) stall-section erase halts the CPU
// (RULE7) load: 00000001 then store within four; the code decodes only bits 4..0, so X0000001 also loads
// (RULE8) only Z word field picks buffer slot
// (RULE9) buffer clears after write, reenable, reset
// (RULE10) software never loads a slot twice
// (RULE11) write: X0000101 then store within four
// (RULE12) software zeroes other Z bits on write
// (RULE13) stall-section write halts the CPU
// (RULE14) ready interrupt level while store-enable clear
// (RULE15) concurrent section reads blocked while programming
// (RULE16) busy flag held during concurrent programming
// (RULE17) software clears busy via reenable bit
// (RULE18) lock set: X0001001, R0 bits 5..2
// (RULE19) flash stays readable during lock programming
// (RULE20) eeprom write blocks programming and lock reads
// (RULE21) lock read with Z=1 within three cycles
// (RULE22) lock-set and enable clear after read/timeout
// (RULE23) store-enable arms store for four cycles
// (RULE24) other low five bit patterns do nothing
// (RULE25) programming busy between 3.7 and 4.5 ms
// (RULE26) store-enable held until programming completes
// (RULE27) page address latched at operation start
`timescale 1ns/10ps
`include "fsps_defines.vh"

module fsps_sequencer #(
  parameter [31:0] PROG_CYCLES = `FSPS_PROG_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        store_instr,
  input  wire        load_instr,
  input  wire [15:0] z_ptr,
  input  wire [15:0] r1r0_data,
  input  wire        eeprom_write_active,
  input  wire [5:0]  flash_rd_idx,
  output reg  [15:0] flash_rd_data,
  output reg         cpu_halt,
  output reg         concurrent_read_block,
  output reg         ready_irq,
  output reg         prog_erase,
  output reg         prog_write,
  output reg         prog_lock,
  output reg  [6:0]  prog_page,
  output reg  [3:0]  boot_lock_bits,
  output reg         load_result_valid,
  output reg  [7:0]  load_result
);
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_ARMED = 4'b0010;
  localparam [3:0] ST_PROG  = 4'b0100;
  localparam [3:0] ST_DONE  = 4'b1000;

  // fuses are not writable from here; reads see their unprogrammed state
  localparam [7:0] FUSE_LOW  = `FSPS_FUSE_LOW_RESET;
  localparam [7:0] FUSE_HIGH = `FSPS_FUSE_HIGH_RESET;
  localparam [7:0] FUSE_EXT  = `FSPS_FUSE_EXT_RESET;

  function is_stall_page;
    input [6:0] page;
    begin
      is_stall_page = (page >= `FSPS_STALL_PAGE_FIRST);
    end
  endfunction

  // only the five listed low-bit patterns arm anything
  function cmd_known;
    input [4:0] c;
    begin
      cmd_known = (c == `FSPS_CMD_LOCK) || (c == `FSPS_CMD_WRITE) ||
                  (c == `FSPS_CMD_ERASE) || (c == `FSPS_CMD_LOAD) ||
                  (c == `FSPS_CMD_REENABLE);
    end
  endfunction

  reg [3:0]  state_q;
  reg        store_en_q;
  reg        erase_q;
  reg        write_q;
  reg        lock_set_q;
  reg        reenable_q;
  reg        ready_ie_q;
  reg        busy_flag_q;
  reg [7:0]  lock_q;
  reg [31:0] prog_cnt_q;
  reg        sync_reset_q;
  reg [7:0]  fuse_lock_byte;
  wire [15:0] buf_rd_data;

  wire       apb_wr  = psel && penable && pwrite && pready;
  wire       apb_rd  = psel && !penable && !pwrite;
  wire       ctrl_wr = apb_wr && (paddr == `FSPS_OFF_CTRL);
  wire [4:0] cmd     = pwdata[4:0];
  // eeprom write stops control writes from arming; the ready-interrupt enable bit still updates
  // a write in the done cycle would restart the timers with no state behind them
  wire       cmd_ok  = !eeprom_write_active && // RULE20
                       (state_q == ST_IDLE || state_q == ST_ARMED) &&
                       cmd_known(cmd); // RULE24
  wire       arm     = ctrl_wr && cmd_ok;

  wire store_act;
  wire store_exp;
  wire load_act;
  // page field sits above the word field; higher z bits are not part of it
  wire [6:0] page_sel = z_ptr[`FSPS_WORD_BITS+`FSPS_PAGE_BITS:`FSPS_WORD_BITS+1];
  wire store_hit = store_instr && store_act && store_en_q;
  wire lock_rd   = load_instr && load_act && lock_set_q && !eeprom_write_active; // RULE21
  wire start_prog = store_hit && (erase_q || write_q || lock_set_q);
  wire word_load  = store_hit && !erase_q && !write_q && !lock_set_q && !reenable_q; // RULE7
  wire done       = (state_q == ST_PROG) && (prog_cnt_q == 32'd1);

  fsps_arm_timer u_store_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (arm),
    .cycles  (`FSPS_STORE_WINDOW), // RULE23
    .hit     (store_hit),
    .active  (store_act),
    .expired (store_exp)
  );

  fsps_arm_timer u_load_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (arm && pwdata[`FSPS_BIT_LOCK_SET]),
    .cycles  (`FSPS_LOAD_WINDOW),
    .hit     (lock_rd),
    .active  (load_act),
    .expired ()
  );

  // slot chosen by word field only, data straight from R1:R0
  fsps_page_buffer u_buffer (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (sync_reset_q), // RULE9
    .wr_en   (word_load), // RULE2 RULE3
    .wr_idx  (z_ptr[`FSPS_WORD_BITS:1]), // RULE8
    .wr_data (r1r0_data),
    .rd_idx  (flash_rd_idx),
    .rd_data (buf_rd_data)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      store_en_q   <= 1'b0;
      erase_q      <= 1'b0;
      write_q      <= 1'b0;
      lock_set_q   <= 1'b0;
      reenable_q   <= 1'b0;
      ready_ie_q   <= 1'b0;
      busy_flag_q  <= 1'b0;
      lock_q       <= `FSPS_LOCK_RESET;
      prog_cnt_q   <= 32'd0;
      sync_reset_q <= 1'b0;
      prog_erase   <= 1'b0;
      prog_write   <= 1'b0;
      prog_lock    <= 1'b0;
      prog_page    <= 7'h00;
      cpu_halt     <= 1'b0;
      boot_lock_bits <= 4'hf;
      load_result_valid <= 1'b0;
      load_result  <= 8'h00;
    end else begin
      sync_reset_q      <= 1'b0;
      prog_erase        <= 1'b0;
      prog_write        <= 1'b0;
      prog_lock         <= 1'b0;
      load_result_valid <= 1'b0;
      if (ctrl_wr) begin
        ready_ie_q <= pwdata[`FSPS_BIT_READY_IE];
      end
      case (state_q)
        ST_IDLE: begin
          if (arm) begin
            store_en_q <= 1'b1;
            erase_q    <= pwdata[`FSPS_BIT_ERASE];
            write_q    <= pwdata[`FSPS_BIT_WRITE];
            lock_set_q <= pwdata[`FSPS_BIT_LOCK_SET];
            reenable_q <= pwdata[`FSPS_BIT_REENABLE];
            state_q    <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (arm) begin
            // a fresh command replaces the pending one and its window
            erase_q    <= pwdata[`FSPS_BIT_ERASE];
            write_q    <= pwdata[`FSPS_BIT_WRITE];
            lock_set_q <= pwdata[`FSPS_BIT_LOCK_SET];
            reenable_q <= pwdata[`FSPS_BIT_REENABLE];
          end else if (lock_rd) begin
            // z selects lock or fuse byte; clears both bits after
            load_result_valid <= 1'b1;
            load_result <= fuse_lock_byte;
            store_en_q  <= 1'b0; // RULE22
            lock_set_q  <= 1'b0;
            state_q     <= ST_IDLE;
          end else if (start_prog) begin
            prog_cnt_q <= PROG_CYCLES; // RULE25
            prog_page  <= page_sel; // RULE5 RULE27
            prog_erase <= erase_q; // RULE4
            prog_write <= write_q; // RULE11
            prog_lock  <= lock_set_q; // RULE18
            if (lock_set_q) begin
              lock_q[5:2] <= lock_q[5:2] & r1r0_data[5:2];
            end
            if ((erase_q || write_q) && !is_stall_page(page_sel)) begin
              busy_flag_q <= 1'b1; // RULE15 RULE16
            end
            // lock programming leaves the whole flash readable
            cpu_halt <= (erase_q || write_q) &&
                        is_stall_page(page_sel); // RULE6 RULE13 RULE19
            state_q  <= ST_PROG;
          end else if (store_hit) begin
            if (reenable_q) begin
              busy_flag_q  <= 1'b0;
              sync_reset_q <= 1'b1;
            end else begin
              busy_flag_q  <= 1'b0; // word load also frees busy flag
            end
            store_en_q <= 1'b0;
            reenable_q <= 1'b0;
            state_q    <= ST_IDLE;
          end else if (store_exp || (!store_act && !load_act)) begin
            store_en_q <= 1'b0; // RULE22 RULE23
            erase_q    <= 1'b0;
            write_q    <= 1'b0;
            lock_set_q <= 1'b0;
            reenable_q <= 1'b0;
            state_q    <= ST_IDLE;
          end
        end
        ST_PROG: begin
          // store-enable stays up for the full programming time
          prog_cnt_q <= prog_cnt_q - 32'd1;
          if (done) begin
            state_q <= ST_DONE; // RULE26
          end
        end
        ST_DONE: begin
          if (write_q) begin
            sync_reset_q <= 1'b1; // RULE9
          end
          boot_lock_bits <= lock_q[5:2];
          cpu_halt   <= 1'b0;
          store_en_q <= 1'b0;
          erase_q    <= 1'b0;
          write_q    <= 1'b0;
          lock_set_q <= 1'b0;
          state_q    <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // z picks the lock byte or one of the fuse bytes for the load-program read
  always @* begin
    case (z_ptr)
      `FSPS_Z_LOCK: begin
        fuse_lock_byte = lock_q;
      end
      `FSPS_Z_FUSE_LOW: begin
        fuse_lock_byte = FUSE_LOW;
      end
      `FSPS_Z_FUSE_HIGH: begin
        fuse_lock_byte = FUSE_HIGH;
      end
      `FSPS_Z_FUSE_EXT: begin
        fuse_lock_byte = FUSE_EXT;
      end
      default: begin
        fuse_lock_byte = 8'hff;
      end
    endcase
  end

  // flop output for the flash macro; data trails the index by one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_rd_data <= 16'hffff;
    end else begin
      flash_rd_data <= buf_rd_data;
    end
  end

  // block reads of concurrent section while busy flag set
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      concurrent_read_block <= 1'b0;
      ready_irq <= 1'b0;
    end else begin
      concurrent_read_block <= busy_flag_q; // RULE15
      ready_irq <= ready_ie_q && !store_en_q; // RULE14
    end
  end

  // apb slave: no wait states, reads registered in setup cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable &&
                 (paddr != `FSPS_OFF_CTRL) && (paddr != `FSPS_OFF_LOCK) &&
                 (paddr != `FSPS_OFF_PAGE) && (paddr != `FSPS_OFF_STATUS);
      if (apb_rd) begin
        case (paddr)
          `FSPS_OFF_CTRL: begin
            prdata <= {24'h000000, ready_ie_q, busy_flag_q, 1'b0, reenable_q,
                       lock_set_q, write_q, erase_q, store_en_q};
          end
          `FSPS_OFF_LOCK: begin
            prdata <= {24'h000000, lock_q};
          end
          `FSPS_OFF_PAGE: begin
            prdata <= {25'h0000000, prog_page};
          end
          `FSPS_OFF_STATUS: begin
            prdata <= {28'h0000000, state_q};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
endmodule // fsps_sequencer

// file: dv/fsps_core_model.sv
// Purpose: core model giving store and load instruction pulses
// Assumes: one-cycle instruction pulses
// Notes:   z and data hold between instructions like cpu registers
`timescale 1ns/10ps
module fsps_core_model (
  input  wire        clk,
  output reg         store_instr = 1'b0,
  output reg         load_instr = 1'b0,
  output reg  [15:0] z_ptr = 16'h0000,
  output reg  [15:0] r1r0_data = 16'h0000
);
  // late idles so the arming window can lapse on purpose
  task automatic issue(input logic ld, input logic [15:0] z, d, input int late);
    repeat (late + 1) @(posedge clk);
    z_ptr <= z;
    r1r0_data <= d;
    store_instr <= !ld;
    load_instr <= ld;
    @(posedge clk);
    store_instr <= 1'b0;
    load_instr <= 1'b0;
  endtask
endmodule // fsps_core_model

// file: dv/fsps_sequencer_checker.sv
// Purpose: port-level checks for the sequencer
// Assumes: single clock, rst_n async active low
// Notes:   page latch may land one cycle after the start pulse
`timescale 1ns/10ps
`include "fsps_defines.vh"
module fsps_sequencer_checker #(
  parameter [31:0] PROG_CYCLES = 32'd50
) (
  input wire       clk,
  input wire       rst_n,
  input wire       load_instr,
  input wire       cpu_halt,
  input wire       concurrent_read_block,
  input wire       ready_irq,
  input wire       prog_erase,
  input wire       prog_write,
  input wire       prog_lock,
  input wire [6:0] prog_page,
  input wire       load_result_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire st = prog_erase | prog_write;
  wire stall = prog_page >= `FSPS_STALL_PAGE_FIRST;
  logic [31:0] halt_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_cnt <= 32'd0;
    end else begin
      halt_cnt <= cpu_halt ? halt_cnt + 32'd1 : 32'd0;
    end
  end
  chk_halt_length: assert property ($fell(cpu_halt) |-> halt_cnt == PROG_CYCLES + 32'd1)
    else $error("cpu halt length differs from programming time");
  chk_pulse_single: assert property (prog_erase |=> !prog_erase)
    else $error("erase start longer than one cycle");
  chk_stall_halt: assert property (st ##1 stall |-> ##[0:1] cpu_halt)
    else $error("stall page programming without cpu halt");
  chk_conc_block: assert property (st ##1 !stall |-> ##[0:1] concurrent_read_block)
    else $error("concurrent page programming without read block");
  chk_irq_held: assert property (st |=> !ready_irq [*8])
    else $error("ready interrupt while programming");
  chk_lock_readable: assert property (prog_lock |=> !cpu_halt [*4])
    else $error("cpu halted during lock programming");
  chk_page_latched: assert property (cpu_halt && $past(cpu_halt) |-> $stable(prog_page))
    else $error("page moved during halted programming");
  chk_start_onehot: assert property ($onehot0({prog_erase, prog_write, prog_lock}))
    else $error("two programming starts at once");
  chk_load_answer: assert property (load_result_valid |-> $past(load_instr))
    else $error("load result without load instruction");
  cover property (st ##1 stall);
  cover property (st ##1 !stall);
  cover property (load_result_valid);
endmodule // fsps_sequencer_checker

bind fsps_sequencer fsps_sequencer_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .load_instr(load_instr), .cpu_halt(cpu_halt),
  .concurrent_read_block(concurrent_read_block), .ready_irq(ready_irq),
  .prog_erase(prog_erase), .prog_write(prog_write), .prog_lock(prog_lock),
  .prog_page(prog_page), .load_result_valid(load_result_valid));

// file: dv/tb_flash_self_program_sequencer.sv
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: PROG_CYCLES shortened to 50
// Notes:   lock byte read back in the same layout as R0
`timescale 1ns/10ps
`include "fsps_defines.vh"
module tb_flash_self_program_sequencer;
  localparam int PROG = 50;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        eeprom_write_active = 1'b0, apb_err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdq;
  logic [5:0]  rd_idx = 6'h00;
  int          error_cnt = 0, check_count = 0, starts = 0;
  wire [31:0]  prdata;
  wire [15:0]  z_ptr, r1r0_data, flash_rd_data;
  wire [6:0]   prog_page;
  wire [7:0]   load_result;
  wire [3:0]   boot_lock_bits;
  wire         pready, pslverr, store_instr, load_instr, cpu_halt, concurrent_read_block;
  wire         ready_irq, prog_erase, prog_write, prog_lock, load_result_valid;
  fsps_core_model core (.clk(clk), .store_instr(store_instr), .load_instr(load_instr),
    .z_ptr(z_ptr), .r1r0_data(r1r0_data));
  fsps_sequencer #(.PROG_CYCLES(PROG)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .store_instr(store_instr), .load_instr(load_instr),
    .z_ptr(z_ptr), .r1r0_data(r1r0_data), .eeprom_write_active(eeprom_write_active),
    .flash_rd_idx(rd_idx), .flash_rd_data(flash_rd_data), .cpu_halt(cpu_halt),
    .concurrent_read_block(concurrent_read_block), .ready_irq(ready_irq),
    .prog_erase(prog_erase), .prog_write(prog_write), .prog_lock(prog_lock),
    .prog_page(prog_page), .boot_lock_bits(boot_lock_bits),
    .load_result_valid(load_result_valid), .load_result(load_result));
  always #4 clk = ~clk;
  always @(posedge clk) if (prog_erase || prog_write || prog_lock) starts <= starts + 1;
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic timeout;
    error_cnt++;
    final_report();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge clk);
    if (n == 20) timeout();
    rdq = prdata;
    apb_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctrl(input logic [7:0] v);
    apb(1'b1, `FSPS_OFF_CTRL, {24'h0, v});
  endtask
  task automatic rd(input logic [5:0] i, input logic [15:0] e);
    @(posedge clk);
    rd_idx <= i;
    @(posedge clk);
    @(posedge clk);
    #1 chk("flash_rd_data", e, flash_rd_data);
  endtask
  task automatic t_regs;
    chk("boot_lock_bits", 4'hf, boot_lock_bits);
    apb(1'b0, `FSPS_OFF_CTRL, 32'h0);
    chk("ctrl", `FSPS_CTRL_RESET, rdq[7:0]);
    apb(1'b0, 12'h040, 32'h0);
    chk("pslverr", 1'b1, apb_err);
  endtask
  task automatic t_load;
    ctrl(8'h81);
    core.issue(0, {9'h000, 6'd5, 1'b0}, 16'h1234, 1);
    ctrl(8'h81);
    core.issue(0, {9'h155, 6'd2, 1'b1}, 16'hbeef, 0);
    rd(5, 16'h1234);
    rd(2, 16'hbeef);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(5, 16'hffff);
  endtask
  task automatic t_prog(input logic [7:0] c, input logic [6:0] pg, input logic s);
    int n;
    ctrl(c);
    core.issue(0, {2'b00, pg, 7'h00}, 16'hffff, 0);
    repeat (3) @(posedge clk);
    #1 chk("prog_page", pg, prog_page);
    chk("cpu_halt", s, cpu_halt);
    chk("read_block", !s, concurrent_read_block);
    core.issue(1, 16'h3f80, 16'h0000, 0);
    repeat (PROG - 8) @(posedge clk);
    chk("ready_irq", 1'b0, ready_irq);
    for (n = 0; ready_irq !== 1'b1 && n < 30; n++) @(posedge clk);
    if (n == 30) timeout();
    #1 chk("cpu_halt", 1'b0, cpu_halt);
    chk("prog_page", pg, prog_page);
  endtask
  task automatic t_reen;
    chk("read_block", 1'b1, concurrent_read_block);
    ctrl(8'h91);
    core.issue(0, 16'h0000, 16'h0000, 0);
    repeat (3) @(posedge clk);
    #1 chk("read_block", 1'b0, concurrent_read_block);
    rd(4, 16'hffff);
  endtask
  task automatic t_refuse;
    int s0;
    s0 = starts;
    ctrl(8'h87);
    core.issue(0, 16'h0800, 16'h0000, 0);
    ctrl(8'h83);
    core.issue(0, 16'h0800, 16'h0000, 4);
    eeprom_write_active <= 1'b1;
    ctrl(8'h83);
    core.issue(0, 16'h0800, 16'h0000, 0);
    repeat (3) @(posedge clk);
    eeprom_write_active <= 1'b0;
    chk("starts", s0, starts);
  endtask
  task automatic t_lock;
    ctrl(8'h89);
    core.issue(0, 16'h0001, 16'h00d7, 0);
    repeat (PROG + 10) @(posedge clk);
    chk("boot_lock_bits", 4'h5, boot_lock_bits);
    ctrl(8'h89);
    core.issue(1, 16'h0001, 16'h0000, 0);
    #1 chk("load_valid", 1'b1, load_result_valid);
    chk("lock_read", 4'h5, load_result[5:2]);
    core.issue(1, 16'h0001, 16'h0000, 0);
    #1 chk("load_valid", 1'b0, load_result_valid);
    apb(1'b0, `FSPS_OFF_CTRL, 32'h0);
    chk("ctrl", 8'h80, rdq[7:0]);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_load();
    t_prog(8'h83, 7'h70, 1'b1);
    ctrl(8'h81);
    core.issue(0, 16'h000e, 16'h5a5a, 0);
    t_prog(8'h85, 7'h70, 1'b1);
    rd(7, 16'hffff);
    ctrl(8'h81);
    core.issue(0, 16'h0008, 16'ha5a5, 0);
    t_prog(8'h83, 7'h10, 1'b0);
    t_reen();
    t_refuse();
    t_lock();
    final_report();
  end
endmodule // tb_flash_self_program_sequencer
